/* File: hw/cgc_pkg.sv */
package cgc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOCK = 8'h01;
  localparam logic [7:0] OFS_MODE_DIVH = 8'h02;
  localparam logic [7:0] OFS_DIVL = 8'h03;
  localparam logic [7:0] OFS_STATE_PICK = 8'h04;
  localparam logic [7:0] OFS_LOAD_CAP = 8'h05;
  localparam logic [7:0] OFS_COUNT_SAVE = 8'h06;
  localparam logic [7:0] OFS_SAFE_LIMIT = 8'h20;
  // ==========================================================
  // Field positions
  localparam int BIT_BUSY = 6;
  localparam int BIT_LOCK = 5;
  localparam int BIT_PIN_SEL = 6;
  localparam int BIT_SAVE = 0;
  localparam logic [7:0] ADDR_LOCK_WMASK = 8'h23;
  localparam logic [7:0] LOAD_CAP_HOST_MASK = 8'hF8;
  localparam logic [4:0] LOAD_CAP_MAX = 5'h14;
  // ==========================================================
  // Reset values, offsets 06h down to 01h
  localparam logic [47:0] REG_RESET = 48'h4050_0201_B401;
  // ==========================================================
  // First output state definitions
  localparam logic [1:0] OUT_POWER_DOWN = 2'h0;
  localparam logic [1:0] OUT_HIZ = 2'h1;
  localparam logic [1:0] OUT_LOW = 2'h2;
  localparam logic [1:0] OUT_ON = 2'h3;
  // ==========================================================
  // Host register word offsets
  localparam logic [4:0] HOFS_SLAVE = 5'h00;
  localparam logic [4:0] HOFS_OFFSET = 5'h04;
  localparam logic [4:0] HOFS_WDATA = 5'h08;
  localparam logic [4:0] HOFS_CMD = 5'h0C;
  localparam logic [4:0] HOFS_RCOUNT = 5'h10;
  localparam logic [4:0] HOFS_STATUS = 5'h14;
  localparam logic [4:0] HOFS_RDATA = 5'h18;
  localparam logic [6:0] HOST_SLAVE_RESET = 7'h65;
  localparam logic [6:0] HOST_RCOUNT_RESET = 7'h20;
  // ==========================================================
  // Link state machines
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_OFS, D_DAT, D_TX, D_DONE} cgc_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_LO, H_RISE, H_FALL, H_STOP1, H_STOP2,
    H_STOP3} cgc_host_st_t;
endpackage : cgc_pkg

/* File: hw/cgc_link_if.sv */
`timescale 1ns/10ps
interface cgc_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Pulled-up wires, data line is open drain
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : cgc_link_if

/* File: hw/cgc_nvm.sv */
`timescale 1ns/10ps
module cgc_nvm #(
  parameter int SAVE_CYCLES = 20000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic save_i,
  input wire logic [47:0] data_i,
  output logic busy_o,
  output logic pin_sel_o,
  output logic lock_o
);
  typedef struct packed {
    logic [6:1][7:0] mem;
    logic [31:0] cnt;
    logic busy;
    logic pin_sel;
    logic lock;
  } cgc_nvm_state_t;

  cgc_nvm_state_t state_reg;
  cgc_nvm_state_t state_next;

  // ==========================================================
  // Save cycle
  always_comb begin
    state_next = state_reg;
    if (state_reg.busy) begin
      if (state_reg.cnt == 32'h0000_0000) begin
        // Stored settings take effect only at the end of the save
        state_next.busy = 1'b0;
        state_next.pin_sel = state_reg.mem[2][cgc_pkg::BIT_PIN_SEL];
        state_next.lock = state_reg.mem[1][cgc_pkg::BIT_LOCK];
      end else begin
        state_next.cnt = state_reg.cnt - 32'h0000_0001;
      end
    end else if (save_i) begin
      state_next.mem = data_i;
      state_next.busy = 1'b1;
      state_next.cnt = 32'(SAVE_CYCLES - 1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '{mem: cgc_pkg::REG_RESET, cnt: 32'h0000_0000, busy: 1'b0,
        pin_sel: 1'b0, lock: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy_o = state_reg.busy;
  assign pin_sel_o = state_reg.pin_sel;
  assign lock_o = state_reg.lock;
endmodule : cgc_nvm

/* File: hw/cgc_dev.sv */
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
module cgc_dev #(
  parameter logic [4:0] ADDR_HIGH = 5'h19, // Arbitrary upper address bits
  parameter logic [7:0] ID_VALUE = 8'h5A, // Arbitrary identification byte
  parameter int SAVE_CYCLES = 20000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  cgc_link_if.dev link,
  input wire logic control_select_pin_0_i,
  input wire logic output_supply_grounded_i,
  output logic [1:0] first_output_mode_o,
  output logic [9:0] first_output_divider_o,
  output logic divider_run_o,
  output logic [4:0] crystal_load_cap_pf_o,
  output logic [2:0] setting_index_o,
  output logic nvm_programming_busy_o,
  output logic serial_active_o
);
  typedef struct packed {
    cgc_pkg::cgc_dev_st_t st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic scl_q;
    logic sda_q;
    logic [7:0] ptr;
    logic [6:0] left;
    logic sda_oe;
    logic [6:1][7:0] regs;
    logic save;
    logic [1:0] mode;
    logic [9:0] div;
    logic div_run;
    logic [4:0] cap;
    logic [2:0] sel;
    logic serial;
  } cgc_dev_state_t;

  cgc_dev_state_t state_reg;
  cgc_dev_state_t state_next;
  logic nvm_busy;
  logic nvm_pin_sel;
  logic nvm_lock;

  // ==========================================================
  // Save engine
  cgc_nvm #(.SAVE_CYCLES(SAVE_CYCLES)) u_nvm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .save_i(state_reg.save),
    .data_i(state_reg.regs),
    .busy_o(nvm_busy),
    .pin_sel_o(nvm_pin_sel),
    .lock_o(nvm_lock)
  );

  // ==========================================================
  // Register read mux
  function automatic logic [7:0] rd_byte(input logic [7:0] ofs, input logic [6:1][7:0] r,
    input logic busy);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      cgc_pkg::OFS_ID: v = ID_VALUE;
      cgc_pkg::OFS_ADDR_LOCK: begin
        v = r[1] & cgc_pkg::ADDR_LOCK_WMASK;
        v[cgc_pkg::BIT_BUSY] = busy;
      end
      cgc_pkg::OFS_MODE_DIVH: v = r[2];
      cgc_pkg::OFS_DIVL: v = r[3];
      cgc_pkg::OFS_STATE_PICK: v = r[4];
      cgc_pkg::OFS_LOAD_CAP: v = r[5];
      cgc_pkg::OFS_COUNT_SAVE: v = r[6];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_byte

  // ==========================================================
  // Link decode and register updates
  always_comb begin
    logic serial;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] b;
    logic [1:0] adr_low;
    logic [6:0] count;
    logic [2:0] sel;
    logic [9:0] div;
    logic [4:0] code;
    serial = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    b = 8'h00;
    adr_low = 2'b00;
    count = 7'h00;
    sel = 3'b000;
    div = 10'h000;
    code = 5'h00;
    state_next = state_reg;
    state_next.save = 1'b0;
    state_next.scl_q = link.scl;
    state_next.sda_q = link.sda;
    // Saved pin choice, overridden by grounded output supply
    serial = ~nvm_pin_sel | output_supply_grounded_i;
    adr_low = output_supply_grounded_i ? 2'b00 : state_reg.regs[1][1:0];
    count = state_reg.regs[6][7:1];
    rise = link.scl & ~state_reg.scl_q;
    fall = ~link.scl & state_reg.scl_q;
    start = link.scl & state_reg.scl_q & state_reg.sda_q & ~link.sda;
    stop = link.scl & state_reg.scl_q & ~state_reg.sda_q & link.sda;
    b = {state_reg.sh[6:0], link.sda};
    if (!serial) begin
      state_next.st = cgc_pkg::D_IDLE;
      state_next.sda_oe = 1'b0;
    end else if (start) begin
      state_next.st = cgc_pkg::D_ADDR;
      state_next.cnt = 3'd0;
    end else if (stop) begin
      state_next.st = cgc_pkg::D_IDLE;
      state_next.sda_oe = 1'b0;
    end else if (rise && state_reg.st == cgc_pkg::D_TX) begin
      state_next.cnt = state_reg.cnt + 3'd1;
      state_next.sh = {state_reg.sh[6:0], 1'b0};
      if (state_reg.cnt == 3'd7) begin
        state_next.ptr = state_reg.ptr + 8'h01;
        state_next.sh = rd_byte(state_reg.ptr + 8'h01, state_reg.regs, nvm_busy);
        state_next.left = state_reg.left - 7'h01;
        if (state_reg.left == 7'h01) begin
          state_next.st = cgc_pkg::D_DONE;
        end
      end
    end else if (rise && (state_reg.st == cgc_pkg::D_ADDR || state_reg.st == cgc_pkg::D_OFS
        || state_reg.st == cgc_pkg::D_DAT)) begin
      state_next.sh = b;
      state_next.cnt = state_reg.cnt + 3'd1;
      if (state_reg.cnt == 3'd7) begin
        case (state_reg.st)
          cgc_pkg::D_ADDR: begin
            if (b[7:1] != {ADDR_HIGH, adr_low}) begin
              state_next.st = cgc_pkg::D_IDLE;
            end else if (!b[0]) begin
              state_next.st = cgc_pkg::D_OFS;
            end else if (count == 7'h00) begin
              state_next.st = cgc_pkg::D_DONE;
            end else begin
              // Block read of count bytes from the pointer
              state_next.st = cgc_pkg::D_TX;
              state_next.left = count;
              state_next.sh = rd_byte(state_reg.ptr, state_reg.regs, nvm_busy);
            end
          end
          cgc_pkg::D_OFS: begin
            state_next.ptr = b;
            state_next.st = cgc_pkg::D_DAT;
          end
          cgc_pkg::D_DAT: begin
            state_next.ptr = state_reg.ptr + 8'h01;
            if (!nvm_busy) begin
              case (state_reg.ptr)
                cgc_pkg::OFS_ADDR_LOCK: state_next.regs[1] = b & cgc_pkg::ADDR_LOCK_WMASK;
                cgc_pkg::OFS_MODE_DIVH: state_next.regs[2] = b;
                cgc_pkg::OFS_DIVL: state_next.regs[3] = b;
                cgc_pkg::OFS_STATE_PICK: state_next.regs[4] = b;
                cgc_pkg::OFS_LOAD_CAP: state_next.regs[5] = b;
                cgc_pkg::OFS_COUNT_SAVE: begin
                  state_next.regs[6] = b;
                  // Save only on a rising trigger, never once locked
                  state_next.save = b[cgc_pkg::BIT_SAVE]
                    & ~state_reg.regs[6][cgc_pkg::BIT_SAVE] & ~nvm_lock;
                end
                default: state_next.regs = state_reg.regs;
              endcase
            end
          end
          default: state_next.st = cgc_pkg::D_IDLE;
        endcase
      end
    end else if (fall) begin
      state_next.sda_oe = (state_reg.st == cgc_pkg::D_TX) & ~state_reg.sh[7];
    end
    // Output decode from the live registers
    sel = serial ? {2'b00, control_select_pin_0_i}
                 : {link.scl, link.sda, control_select_pin_0_i};
    state_next.sel = sel;
    state_next.mode = state_reg.regs[4][sel] ? state_reg.regs[2][5:4]
                                             : state_reg.regs[2][3:2];
    div = {state_reg.regs[2][1:0], state_reg.regs[3]};
    state_next.div = div;
    state_next.div_run = div != 10'h000;
    code = state_reg.regs[5][7:3];
    state_next.cap = (code > cgc_pkg::LOAD_CAP_MAX) ? cgc_pkg::LOAD_CAP_MAX : code;
    state_next.serial = serial;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '{st: cgc_pkg::D_IDLE, sh: 8'h00, cnt: 3'd0, scl_q: 1'b1, sda_q: 1'b1,
        ptr: 8'h00, left: 7'h00, sda_oe: 1'b0, regs: cgc_pkg::REG_RESET, save: 1'b0,
        mode: cgc_pkg::OUT_HIZ, div: 10'h001, div_run: 1'b1, cap: 5'h0A, sel: 3'b000,
        serial: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = state_reg.sda_oe;
  assign first_output_mode_o = state_reg.mode;
  assign first_output_divider_o = state_reg.div;
  assign divider_run_o = state_reg.div_run;
  assign crystal_load_cap_pf_o = state_reg.cap;
  assign setting_index_o = state_reg.sel;
  assign nvm_programming_busy_o = nvm_busy;
  assign serial_active_o = state_reg.serial;
endmodule : cgc_dev

/* File: hw/cgc_host.sv */
`timescale 1ns/10ps
module cgc_host #(
  parameter int HALF_CYCLES = 63
) (
  input wire logic clk_i,
  input wire logic rst_i,
  cgc_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef struct packed {
    cgc_pkg::cgc_host_st_t st;
    logic [6:0] slave;
    logic [7:0] offset;
    logic [7:0] wdata;
    logic [6:0] rcount;
    logic [7:0] rdata;
    logic busy;
    logic refused;
    logic rd;
    logic ofs_only;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [7:0] bi;
    logic [7:0] total;
    logic [15:0] tick;
    logic scl;
    logic sda_oe;
    logic ack;
    logic [31:0] dat;
  } cgc_host_state_t;

  cgc_host_state_t state_reg;
  cgc_host_state_t state_next;

  // ==========================================================
  // Wishbone slave and link engine
  always_comb begin
    logic req;
    logic tick;
    logic [7:0] nb;
    req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    tick = state_reg.tick == 16'h0000;
    nb = 8'h00;
    state_next = state_reg;
    state_next.ack = req;
    state_next.tick = tick ? 16'(HALF_CYCLES - 1) : state_reg.tick - 16'h0001;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        cgc_pkg::HOFS_SLAVE: state_next.dat = {25'h000_0000, state_reg.slave};
        cgc_pkg::HOFS_OFFSET: state_next.dat = {24'h00_0000, state_reg.offset};
        cgc_pkg::HOFS_WDATA: state_next.dat = {24'h00_0000, state_reg.wdata};
        cgc_pkg::HOFS_RCOUNT: state_next.dat = {25'h000_0000, state_reg.rcount};
        cgc_pkg::HOFS_STATUS: state_next.dat = {30'h0000_0000, state_reg.refused,
          state_reg.busy};
        cgc_pkg::HOFS_RDATA: state_next.dat = {24'h00_0000, state_reg.rdata};
        default: state_next.dat = 32'h0000_0000;
      endcase
    end
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        cgc_pkg::HOFS_SLAVE: state_next.slave = wb_dat_i[6:0];
        cgc_pkg::HOFS_OFFSET: state_next.offset = wb_dat_i[7:0];
        cgc_pkg::HOFS_WDATA: state_next.wdata = wb_dat_i[7:0];
        cgc_pkg::HOFS_RCOUNT: state_next.rcount = wb_dat_i[6:0];
        cgc_pkg::HOFS_CMD: begin
          if (!state_reg.busy && (wb_dat_i[0] || wb_dat_i[1])) begin
            // Writes past the safe range are refused outright
            if (!wb_dat_i[1] && state_reg.offset > cgc_pkg::OFS_SAFE_LIMIT) begin
              state_next.refused = 1'b1;
            end else begin
              state_next.refused = 1'b0;
              state_next.busy = 1'b1;
              state_next.rd = wb_dat_i[1];
              state_next.ofs_only = wb_dat_i[2];
              state_next.total = wb_dat_i[1] ? {1'b0, state_reg.rcount} + 8'h01
                                             : (wb_dat_i[2] ? 8'h02 : 8'h03);
            end
          end
        end
        default: state_next.slave = state_reg.slave;
      endcase
    end
    if (tick) begin
      case (state_reg.st)
        cgc_pkg::H_IDLE: begin
          if (state_reg.busy) begin
            state_next.sda_oe = 1'b1;
            state_next.st = cgc_pkg::H_START;
          end
        end
        cgc_pkg::H_START: begin
          state_next.scl = 1'b0;
          state_next.sh = {state_reg.slave, state_reg.rd};
          state_next.bi = 8'h00;
          state_next.bitn = 3'd0;
          state_next.st = cgc_pkg::H_LO;
        end
        cgc_pkg::H_LO: begin
          // Receive bytes leave the line released
          state_next.sda_oe = ~(state_reg.rd && state_reg.bi != 8'h00) & ~state_reg.sh[7];
          state_next.st = cgc_pkg::H_RISE;
        end
        cgc_pkg::H_RISE: begin
          state_next.scl = 1'b1;
          state_next.st = cgc_pkg::H_FALL;
        end
        cgc_pkg::H_FALL: begin
          state_next.scl = 1'b0;
          state_next.sh = {state_reg.sh[6:0], link.sda};
          state_next.bitn = state_reg.bitn + 3'd1;
          state_next.st = cgc_pkg::H_LO;
          if (state_reg.bitn == 3'd7) begin
            nb = state_reg.bi + 8'h01;
            state_next.bi = nb;
            if (state_reg.rd && state_reg.bi == 8'h01) begin
              state_next.rdata = {state_reg.sh[6:0], link.sda};
            end
            if (nb == 8'h01 && !state_reg.rd) begin
              state_next.sh = state_reg.offset;
            end else if (nb == 8'h02 && !state_reg.rd) begin
              state_next.sh = (state_reg.offset == cgc_pkg::OFS_LOAD_CAP)
                ? (state_reg.wdata & cgc_pkg::LOAD_CAP_HOST_MASK) : state_reg.wdata;
            end
            // Every byte of a block read is clocked out
            if (nb == state_reg.total) begin
              state_next.st = cgc_pkg::H_STOP1;
            end
          end
        end
        cgc_pkg::H_STOP1: begin
          state_next.sda_oe = 1'b1;
          state_next.st = cgc_pkg::H_STOP2;
        end
        cgc_pkg::H_STOP2: begin
          state_next.scl = 1'b1;
          state_next.st = cgc_pkg::H_STOP3;
        end
        cgc_pkg::H_STOP3: begin
          state_next.sda_oe = 1'b0;
          state_next.busy = 1'b0;
          state_next.st = cgc_pkg::H_IDLE;
        end
        default: state_next.st = cgc_pkg::H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '{st: cgc_pkg::H_IDLE, slave: cgc_pkg::HOST_SLAVE_RESET, offset: 8'h00,
        wdata: 8'h00, rcount: cgc_pkg::HOST_RCOUNT_RESET, rdata: 8'h00, busy: 1'b0,
        refused: 1'b0, rd: 1'b0, ofs_only: 1'b0, sh: 8'h00, bitn: 3'd0, bi: 8'h00,
        total: 8'h00, tick: 16'h0000, scl: 1'b1, sda_oe: 1'b0, ack: 1'b0,
        dat: 32'h0000_0000};
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign link.host_scl_o = state_reg.scl;
  assign link.host_scl_oe = 1'b1;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = state_reg.sda_oe;
  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
endmodule : cgc_host

/* File: bench/cgc_link_monitor.sv */
`timescale 1ns/10ps
module cgc_link_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // Wire checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  open_drain_a: assert property (!host_sda_o && !dev_sda_o && host_scl_oe)
    else $error("data line driven high or clock released");
  no_fight_a: assert property (!(host_sda_oe && dev_sda_oe))
    else $error("both ends pull the data line");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  scl_high_a: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  low_bound_a: assert property ($fell(scl) |-> ##[1:16] scl)
    else $error("clock held low too long");
  start_frame_a: assert property ($rose(host_sda_oe) && scl |-> ##[1:8] !scl)
    else $error("start not followed by clock low");
  idle_reset_a: assert property ($fell(rst_i) |-> scl && sda && !host_sda_oe)
    else $error("bus not idle after reset");
  sda_hold_a: assert property (scl && $past(scl) && $changed(sda)
      |-> !dev_sda_oe && !$past(dev_sda_oe))
    else $error("device moved data while clock high");
  // Main scenarios
  cover property ($rose(dev_sda_oe));
  cover property ($rose(host_sda_oe) && scl);
  cover property ($fell(scl));
endmodule : cgc_link_monitor

/* File: bench/clock_gen_config_eeprom_ctrl_test.sv */
`timescale 1ns/10ps
module clock_gen_config_eeprom_ctrl_test;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, s0, gnd, run, nvm_busy, serial;
  logic [4:0] wb_adr, cap, cd;
  logic [31:0] wb_dw, wb_dr, rd;
  logic [1:0] mode, st;
  logic [9:0] div, dv;
  logic [2:0] idx;
  logic [7:0] pk;
  int num_errors = 0, n_compared = 0, busy_cnt = 0, b0, seed;
  cgc_link_if link_bus();
  cgc_host #(.HALF_CYCLES(4)) cgc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_bus),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'h1), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack));
  cgc_dev #(.SAVE_CYCLES(2000)) cgc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link_bus),
    .control_select_pin_0_i(s0), .output_supply_grounded_i(gnd), .first_output_mode_o(mode),
    .first_output_divider_o(div), .divider_run_o(run), .crystal_load_cap_pf_o(cap),
    .setting_index_o(idx), .nvm_programming_busy_o(nvm_busy), .serial_active_o(serial));
  cgc_link_monitor cgc_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .host_scl_o(link_bus.host_scl_o), .host_scl_oe(link_bus.host_scl_oe),
    .host_sda_o(link_bus.host_sda_o), .host_sda_oe(link_bus.host_sda_oe),
    .dev_sda_o(link_bus.dev_sda_o), .dev_sda_oe(link_bus.dev_sda_oe),
    .scl(link_bus.scl), .sda(link_bus.sda));
  // ==========================================================
  // Clock, busy counter, watchdog
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (nvm_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  initial begin
    repeat (50000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end
  // ==========================================================
  // Tasks
  task end_sim;
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask : chk
  // Expected load capacitance in pF for a code
  function automatic logic [4:0] exp_cap(input logic [4:0] c);
    return (c > 5'd20) ? 5'd20 : c;
  endfunction : exp_cap
  // Expected first output state, state zero written as inverse of state one
  function automatic logic [1:0] exp_mode(input logic [7:0] p, input logic [2:0] s,
    input logic [1:0] st1);
    return p[s] ? st1 : ~st1;
  endfunction : exp_mode
  // Classic Wishbone cycle, read data left in rd
  task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dw <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_dr;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
  endtask : wb
  // Link command, then poll until the host is idle
  task hcmd(input logic [7:0] o, input logic [7:0] d, input logic [2:0] c);
    wb(1'b1, cgc_pkg::HOFS_OFFSET, {24'h0, o});
    wb(1'b1, cgc_pkg::HOFS_WDATA, {24'h0, d});
    wb(1'b1, cgc_pkg::HOFS_CMD, {29'h0, c});
    do wb(1'b0, cgc_pkg::HOFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : hcmd
  task dread(input logic [7:0] o);
    hcmd(o, 8'h00, 3'h5);
    hcmd(o, 8'h00, 3'h2);
    wb(1'b0, cgc_pkg::HOFS_RDATA, 32'h0);
  endtask : dread
  task save_wait;
    while (nvm_busy !== 1'b0) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask : save_wait
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'he4ab_1a8a;
    rst_i = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 5'h00;
    wb_dw = 32'h0; s0 = 1'b0; gnd = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, cgc_pkg::HOFS_SLAVE, 32'h0); chk("slave", 32'h65, rd);
    wb(1'b0, cgc_pkg::HOFS_RCOUNT, 32'h0); chk("rcount", 32'h20, rd);
    wb(1'b0, 5'h1C, 32'h0); chk("unmapped", 32'h0, rd);
    chk("cap_rst", 32'd10, cap);
    chk("div_rst", 32'h1, div);
    dread(cgc_pkg::OFS_COUNT_SAVE); chk("count_rst", 32'h40, rd[7:0]);
    // One-byte block reads on both ends from here on
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h02, 3'h1);
    wb(1'b1, cgc_pkg::HOFS_RCOUNT, 32'h1);
    dread(cgc_pkg::OFS_COUNT_SAVE); chk("count_set", 32'h02, rd[7:0]);
    dread(cgc_pkg::OFS_DIVL); chk("divl_rd", 32'h01, rd[7:0]);
    // Divider, state definitions and per-setting picks
    for (int i = 0; i < 4; i++) begin
      st = 2'(i);
      dv = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : (i == 2) ? 10'h001 : 10'($random(seed));
      pk = 8'($random(seed));
      hcmd(cgc_pkg::OFS_MODE_DIVH, {2'b10, st, ~st, dv[9:8]}, 3'h1);
      hcmd(cgc_pkg::OFS_DIVL, dv[7:0], 3'h1);
      hcmd(cgc_pkg::OFS_STATE_PICK, pk, 3'h1);
      chk("divider", dv, div);
      chk("run", dv != 0, run);
      for (int v = 0; v < 2; v++) begin
        s0 <= v[0];
        repeat (3) @(posedge clk_i);
        chk("sel", {2'b00, v[0]}, idx);
        chk("mode", exp_mode(pk, {2'b00, v[0]}, st), mode);
      end
    end
    // Load capacitance codes with clamp
    for (int i = 0; i < 6; i++) begin
      cd = (i == 0) ? 5'h00 : (i == 1) ? 5'h13 : (i == 2) ? 5'h14 : 5'($random(seed));
      if (i == 3) cd = 5'h1F;
      hcmd(cgc_pkg::OFS_LOAD_CAP, {cd, 3'($random(seed))}, 3'h1);
      chk("cap_pf", exp_cap(cd), cap);
      dread(cgc_pkg::OFS_LOAD_CAP); chk("cap_low", 32'h0, rd[2:0]);
    end
    hcmd(8'h21, 8'h00, 3'h1); chk("refused", 32'h1, rd[1]);
    // Plain save, then a static high trigger
    b0 = busy_cnt;
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h03, 3'h1); chk("busy_on", 32'h1, nvm_busy);
    save_wait();
    chk("busy_len", 32'd2000, busy_cnt - b0);
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h03, 3'h1); chk("no_retrig", 32'h0, nvm_busy);
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h02, 3'h1);
    // Save with pin select and lock held only in registers
    hcmd(cgc_pkg::OFS_MODE_DIVH, 8'hF4 | {6'h0, dv[9:8]}, 3'h1);
    chk("serial_pre", 32'h1, serial);
    hcmd(cgc_pkg::OFS_ADDR_LOCK, 8'h21, 3'h1);
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h03, 3'h1); chk("save_unlk", 32'h1, nvm_busy);
    hcmd(cgc_pkg::OFS_DIVL, ~dv[7:0], 3'h1);
    dread(cgc_pkg::OFS_ADDR_LOCK); chk("busy_flag", 32'h1, rd[6]);
    chk("serial_mid", 32'h1, serial);
    save_wait();
    chk("serial_off", 32'h0, serial);
    chk("sel_pins", {2'b11, s0}, idx);
    gnd <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("serial_gnd", 32'h1, serial);
    wb(1'b1, cgc_pkg::HOFS_SLAVE, 32'h64);
    dread(cgc_pkg::OFS_DIVL); chk("dropped", dv[7:0], rd[7:0]);
    // Stored lock refuses saves, writes still act
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h02, 3'h1);
    hcmd(cgc_pkg::OFS_COUNT_SAVE, 8'h03, 3'h1); chk("locked", 32'h0, nvm_busy);
    hcmd(cgc_pkg::OFS_DIVL, 8'h33, 3'h1); chk("live_wr", 32'h33, div[7:0]);
    end_sim();
  end
endmodule : clock_gen_config_eeprom_ctrl_test
